// ---- inc/sqsel_pkg.sv ----
// Sequence select and start block: shared constants and types.
// Assumes a single 20 MHz clock domain with synchronous reset.
package sqsel_pkg;
  localparam int          NUM_INPUTS   = 9;
  localparam int          SEL_INPUTS   = 7;
  localparam int          SEG_COUNT    = 8;
  localparam logic [6:0]  MAX_SEQ      = 7'h63;
  // Offsets of the register port (word indices)
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_ASSIGN  = 4'h1;
  localparam logic [3:0]  ADDR_USEDMSK = 4'h2;
  localparam logic [3:0]  ADDR_RUNCMD  = 4'h3;
  localparam logic [3:0]  ADDR_STATUS  = 4'h4;
  localparam logic [3:0]  ADDR_CHAIN   = 4'h5;
  localparam logic [3:0]  ADDR_STEP    = 4'h6;
  // Field positions
  localparam int          CTRL_LEVEL   = 0;
  localparam int          CTRL_TRACE   = 1;
  localparam int          ASG_ABORT_LO = 4;
  // Reset values
  localparam logic [3:0]  START_ASG_RST = 4'h9;
  localparam logic [3:0]  ABORT_ASG_RST = 4'h0;
  localparam logic [8:0]  USED_RST      = 9'h000;
  localparam logic [7:0]  CHAIN_RST     = 8'h00;

  typedef enum logic [1:0] {
    SQSEL_IDLE   = 2'b00,
    SQSEL_RUN    = 2'b01,
    SQSEL_PAUSED = 2'b10
  } sqsel_state_t;
endpackage

// ---- inc/sqsel_sync_if.sv ----
// Carrier between the top and its input synchroniser.
// Holds the raw pins and the synchronised copy.
`timescale 1ns/100ps
`default_nettype none
interface sqsel_sync_if #(parameter int W = 9);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface
`default_nettype wire

// ---- design/sqsel_sync.sv ----
// Two-stage synchroniser for the discrete inputs.
// Assumes raw pins are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module sqsel_sync (
  input wire logic clk,      // System clock
  input wire logic srst,     // Synchronous reset
  sqsel_sync_if.sync bus     // Raw in, synchronised out
);
  logic [$bits(bus.raw)-1:0] stage1_r;
  logic [$bits(bus.raw)-1:0] stage2_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= bus.raw;
      stage2_r <= stage1_r;
    end
  end

  assign bus.synced = stage2_r;
endmodule // sqsel_sync
`default_nettype wire

// ---- design/sqsel_top.sv ----
// Sequence select and start: input mapping, start/abort, run and chaining.
// Assumes a simple register port and a sequencer that acks each step.
`timescale 1ns/100ps
`default_nettype none
module sqsel_top
  import sqsel_pkg::*;
#(
  parameter int NIN = NUM_INPUTS
) (
  input  wire logic           clk,        // 20 MHz clock
  input  wire logic           srst,       // Sync reset, active high
  input  wire logic [NIN-1:0] inPins,     // Discrete inputs 1..9
  input  wire logic [3:0]     regAddr,    // Register index
  input  wire logic [31:0]    regWdata,   // Write data
  input  wire logic           regWr,      // Write strobe
  input  wire logic           regRd,      // Read strobe
  output logic      [31:0]    regRdata,   // Read data, cycle after strobe
  input  wire logic           stepDone,   // Sequencer finished a statement
  input  wire logic           segDone,    // Current segment finished
  input  wire logic           seqEnd,     // Sequencer reached end
  output logic                running,    // Sequence active
  output logic                paused,     // Motion paused
  output logic                resumePulse,// Resume paused motion
  output logic                abortPulse, // Abort request
  output logic      [6:0]     seqNum,     // Held sequence number
  output logic      [2:0]     segNum,     // Current segment
  output logic                traceValid  // Statement executed, trace on
);
  sqsel_state_t state_r;
  logic [3:0]   startAsg_r;
  logic [3:0]   abortAsg_r;
  logic [8:0]   otherUse_r;
  logic         levelMode_r;
  logic         trace_r;
  logic [7:0]   chain_r;
  logic [15:0]  stepCnt_r;
  logic         startPrev_r;
  logic         startIn;
  logic         abortIn;
  logic         startRise;
  logic         startFall;
  logic [6:0]   selVal;
  logic         runCmd;
  logic [6:0]   runNum;
  logic [NIN-1:0] pinSync;

  sqsel_sync_if #(.W(NIN)) syncBus ();
  assign syncBus.raw = inPins;
  assign pinSync     = syncBus.synced;

  sqsel_sync u_sync (
    .clk  (clk),
    .srst (srst),
    .bus  (syncBus)
  );

  // Assignment 0 means unmapped
  always_comb begin
    startIn = 1'b0;
    abortIn = 1'b0;
    if (startAsg_r != 4'h0 && startAsg_r <= 4'(NIN)) begin
      startIn = pinSync[startAsg_r - 4'h1];
    end
    if (abortAsg_r != 4'h0 && abortAsg_r <= 4'(NIN)) begin
      abortIn = pinSync[abortAsg_r - 4'h1];
    end
  end

  // Inputs used by start, abort or other functions read as zero
  always_comb begin
    logic [8:0] used;
    used = otherUse_r;
    if (startAsg_r != 4'h0 && startAsg_r <= 4'h9) begin
      used[startAsg_r - 4'h1] = 1'b1;
    end
    if (abortAsg_r != 4'h0 && abortAsg_r <= 4'h9) begin
      used[abortAsg_r - 4'h1] = 1'b1;
    end
    selVal = pinSync[SEL_INPUTS-1:0] & ~used[SEL_INPUTS-1:0];
  end

  assign startRise = startIn & ~startPrev_r;
  assign startFall = ~startIn & startPrev_r;
  assign runCmd    = regWr && regAddr == ADDR_RUNCMD
                     && regWdata[6:0] <= MAX_SEQ;
  assign runNum    = regWdata[6:0];

  always_ff @(posedge clk) begin
    if (srst) begin
      startPrev_r <= 1'b0;
    end else begin
      startPrev_r <= startIn;
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (srst) begin
      levelMode_r <= 1'b0;
      trace_r     <= 1'b0;
      startAsg_r  <= START_ASG_RST;
      abortAsg_r  <= ABORT_ASG_RST;
      otherUse_r  <= USED_RST;
      chain_r     <= CHAIN_RST;
    end else if (regWr) begin
      unique case (regAddr)
        ADDR_CTRL: begin
          levelMode_r <= regWdata[CTRL_LEVEL];
          trace_r     <= regWdata[CTRL_TRACE];
        end
        ADDR_ASSIGN: begin
          startAsg_r <= regWdata[3:0];
          abortAsg_r <= regWdata[ASG_ABORT_LO +: 4];
        end
        ADDR_USEDMSK: otherUse_r <= regWdata[8:0];
        ADDR_CHAIN:   chain_r    <= regWdata[7:0];
        default: ;
      endcase
    end
  end

  // Run state machine
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r     <= SQSEL_IDLE;
      seqNum      <= 7'h00;
      segNum      <= 3'h0;
      resumePulse <= 1'b0;
      abortPulse  <= 1'b0;
    end else begin
      resumePulse <= 1'b0;
      abortPulse  <= 1'b0;
      unique case (state_r)
        SQSEL_IDLE: begin
          if (startRise && selVal <= MAX_SEQ) begin
            seqNum  <= selVal;
            segNum  <= 3'h0;
            state_r <= SQSEL_RUN;
          end else if (runCmd) begin
            seqNum  <= runNum;
            segNum  <= 3'h0;
            state_r <= SQSEL_RUN;
          end
        end
        SQSEL_RUN, SQSEL_PAUSED: begin
          if (abortIn || (levelMode_r && startFall)) begin
            abortPulse <= 1'b1;
            state_r    <= SQSEL_IDLE;
          end else if (seqEnd) begin
            state_r <= SQSEL_IDLE;
          end else if (state_r == SQSEL_PAUSED && startRise) begin
            resumePulse <= 1'b1;
            state_r     <= SQSEL_RUN;
          end else if (segDone) begin
            if (chain_r[segNum]) begin
              segNum <= segNum + 3'h1;
            end else begin
              state_r <= SQSEL_PAUSED;
            end
          end
        end
        default: state_r <= SQSEL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      running <= 1'b0;
      paused  <= 1'b0;
    end else begin
      running <= state_r != SQSEL_IDLE;
      paused  <= state_r == SQSEL_PAUSED;
    end
  end

  // Trace reporting
  always_ff @(posedge clk) begin
    if (srst) begin
      traceValid <= 1'b0;
      stepCnt_r  <= 16'h0000;
    end else begin
      traceValid <= trace_r && stepDone && state_r != SQSEL_IDLE;
      if (stepDone && state_r != SQSEL_IDLE) begin
        stepCnt_r <= stepCnt_r + 16'h0001;
      end
    end
  end

  // Read port
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_CTRL:    regRdata <= {30'h0, trace_r, levelMode_r};
        ADDR_ASSIGN:  regRdata <= {24'h0, abortAsg_r, startAsg_r};
        ADDR_USEDMSK: regRdata <= {23'h0, otherUse_r};
        ADDR_STATUS:  regRdata <= {20'h0, state_r, segNum, seqNum};
        ADDR_CHAIN:   regRdata <= {24'h0, chain_r};
        ADDR_STEP:    regRdata <= {16'h0, stepCnt_r};
        default:      regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end
endmodule // sqsel_top
`default_nettype wire

// ---- test/sqsel_asserts.sv ----
// Port checker for sqsel_top.
// Bound to every sqsel_top instance.
`timescale 1ns/100ps
`default_nettype none
module sqsel_asserts
  import sqsel_pkg::*;
(
  input wire logic        clk,         // Clock
  input wire logic        srst,        // Reset
  input wire logic        regRd,       // Read strobe
  input wire logic [31:0] regRdata,    // Read data
  input wire logic        segDone,     // Segment end
  input wire logic        running,     // Active
  input wire logic        paused,      // Paused
  input wire logic        resumePulse, // Resume
  input wire logic        abortPulse,  // Abort
  input wire logic [6:0]  seqNum,      // Number
  input wire logic        traceValid   // Trace
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_abort;
    abortPulse;
  endsequence
  sequence s_held;
    running && $past(running);
  endsequence
  AST_RANGE: assert property (running |-> seqNum <= MAX_SEQ)
    else $error("number out of range");
  AST_HELD: assert property (s_held |-> $stable(seqNum))
    else $error("number changed in run");
  AST_ABORT: assert property (s_abort |-> ##[1:3] !running)
    else $error("abort did not stop");
  AST_RESUME: assert property (resumePulse |-> paused)
    else $error("resume while not paused");
  AST_TRACE: assert property (traceValid |-> running)
    else $error("trace while idle");
  AST_PAUSE_RUN: assert property (paused |-> running)
    else $error("paused while idle");
  AST_PAUSE_CAUSE: assert property ($rose(paused) |->
    $past(segDone) || $past(segDone, 2))
    else $error("pause without segment end");
  AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside slot");
endmodule // sqsel_asserts
bind sqsel_top sqsel_asserts u_chk (.clk(clk), .srst(srst), .regRd(regRd),
  .regRdata(regRdata), .segDone(segDone), .running(running),
  .paused(paused), .resumePulse(resumePulse), .abortPulse(abortPulse),
  .seqNum(seqNum), .traceValid(traceValid));
`default_nettype wire

// ---- test/sqsel_host.sv ----
// Host controller model driving the discrete inputs.
// Start on IN9, abort on IN8, selection on IN1..IN7.
`timescale 1ns/100ps
`default_nettype none
module sqsel_host (
  input  wire logic       clk,      // Clock
  input  wire logic [6:0] selCode,  // Selection
  input  wire logic       startLvl, // Start level
  input  wire logic       abortLvl, // Abort level
  output logic      [8:0] inPins    // Discrete inputs
);
  always @(posedge clk) begin
    inPins <= {startLvl, abortLvl, selCode};
  end
endmodule // sqsel_host
`default_nettype wire

// ---- test/sequence_select_and_start_bench.sv ----
// Bench for sqsel_top: register tasks, host pins, sequencer pulses.
// Assumes the host model and bound checker are compiled.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch %0t got %h exp %h", $time, a, e); end end
module sequence_select_and_start_bench;
  import sqsel_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic        startLvl = 1'b0, abortLvl = 1'b0;
  logic [2:0]  ev = 3'h0;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic [6:0]  selCode = 7'h00;
  wire  [8:0]  inPins;
  wire  [31:0] regRdata;
  wire  [6:0]  seqNum;
  wire  [2:0]  segNum;
  wire         running, paused, resumePulse, abortPulse, traceValid;
  int          error_cnt = 0, n_tests = 0, nTrace = 0, nRes = 0, nAbt = 0;
  always #25 clk = ~clk;
  sqsel_host host (.clk(clk), .selCode(selCode), .startLvl(startLvl),
    .abortLvl(abortLvl), .inPins(inPins));
  sqsel_top dut (.clk(clk), .srst(srst), .inPins(inPins),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .stepDone(ev[0]), .segDone(ev[1]),
    .seqEnd(ev[2]), .running(running), .paused(paused),
    .resumePulse(resumePulse), .abortPulse(abortPulse), .seqNum(seqNum),
    .segNum(segNum), .traceValid(traceValid));
  always @(posedge clk) begin
    if (!srst) begin
      nTrace += traceValid;
      nRes += resumePulse;
      nAbt += abortPulse;
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic ck(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    `CHK(regRdata, e)
  endtask
  task automatic pin(input logic s, input logic b, input logic [6:0] c);
    @(posedge clk);
    startLvl <= s;
    abortLvl <= b;
    selCode <= c;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 3'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    ck(ADDR_STATUS, 32'h0);
    ck(ADDR_ASSIGN, 32'h9);
    ck(4'hf, 32'h0);
    wr(ADDR_ASSIGN, 32'h89);
    wr(ADDR_USEDMSK, 32'h4);
    pin(1'b1, 1'b0, 7'h67);
    ck(ADDR_STATUS, 32'h463);
    pin(1'b1, 1'b0, 7'h01);
    ck(ADDR_STATUS, 32'h463);
    wr(ADDR_CTRL, 32'h2);
    pulse(3'b001);
    pulse(3'b001);
    ck(ADDR_STEP, 32'h2);
    `CHK(nTrace, 2)
    $display("select and trace done");
    wr(ADDR_CHAIN, 32'h3);
    repeat (3) pulse(3'b010);
    ck(ADDR_STATUS, 32'h963);
    `CHK(paused, 1'b1)
    pin(1'b0, 1'b0, 7'h01);
    ck(ADDR_STATUS, 32'h963);
    pin(1'b1, 1'b0, 7'h01);
    `CHK(nRes, 1)
    `CHK(paused, 1'b0)
    pin(1'b1, 1'b1, 7'h01);
    pin(1'b1, 1'b0, 7'h01);
    `CHK(running, 1'b0)
    `CHK(nAbt, 1)
    $display("chain and abort done");
    wr(ADDR_CTRL, 32'h1);
    pin(1'b0, 1'b0, 7'h05);
    pin(1'b1, 1'b0, 7'h05);
    `CHK(seqNum, 7'h01)
    pin(1'b0, 1'b0, 7'h05);
    `CHK(running, 1'b0)
    `CHK(nAbt, 2)
    $display("level mode done");
    wr(ADDR_RUNCMD, 32'h64);
    ck(ADDR_STATUS, {20'h0, 2'h0, 3'h0, 7'h01});
    wr(ADDR_RUNCMD, 32'h2a);
    ck(ADDR_STATUS, 32'h42a);
    pulse(3'b100);
    `CHK(running, 1'b0)
    $display("run command done");
    give_verdict;
  end
endmodule // sequence_select_and_start_bench
`undef CHK
`default_nettype wire
